// File: src/itc_pkg.sv
// Overview of operation
// - Counter pulse is rise then fall; trigger gate rise
// - Mode 0 output low until zero, then high
// - Mode 0 count loads undecremented; high after N+1
// - Mode 0 first byte halts, drives low at once
// - Mode 0 gate suspends counting; loads regardless
// - Mode 1 trigger loads, output low N pulses
// - Mode 1 every trigger restarts the one-shot
// - Mode 1 new count used only on retrigger
// - Mode 2 one-pulse low at count 1, reload
// - Mode 2 gate low forces high; trigger reloads
// - Mode 2 new count waits for period end
// - Mode 3 square wave with period N
// - Mode 3 gate low forces high; trigger reloads
// - Mode 3 new count waits for half-cycle end
// - Mode 3 even counts decrement by two
// - Mode 3 odd counts use one/three then two
// - Mode 4 write starts; strobe after N+1 pulses
// - Mode 4 first byte ignored; second byte retriggers
// - Mode 5 trigger loads next pulse; strobe N+1
// - Mode 5 new count used on later trigger
// - Loads and decrements happen on falling counter edge
// - Gate sampled on rising edge; trigger captured
// - Modes 0,1,4,5 wrap past zero and continue
// - Initial count zero acts as largest count
package itc_pkg;

	localparam int CW = 16;

	typedef enum logic [2:0] {
		MODE_TERM  = 3'b000,
		MODE_ONESH = 3'b001,
		MODE_RATE  = 3'b010,
		MODE_SQUAR = 3'b011,
		MODE_SWSTB = 3'b100,
		MODE_HWSTB = 3'b101
	} itc_mode_t;

	typedef enum logic [1:0] {
		RW_LSB  = 2'b01,
		RW_MSB  = 2'b10,
		RW_BOTH = 2'b11
	} itc_rw_t;

	typedef enum logic [1:0] {
		RUN_IDLE  = 2'b00,
		RUN_LOAD  = 2'b01,
		RUN_COUNT = 2'b10
	} itc_run_t;

	localparam itc_mode_t MODE_RST  = MODE_TERM;
	localparam itc_rw_t   RW_RST    = RW_LSB;
	localparam logic      OUT_RST   = 1'b0;
	localparam logic [CW-1:0] COUNT_RST = 16'h0000;
	localparam logic [1:0] STEP_ONE   = 2'h1;
	localparam logic [1:0] STEP_TWO   = 2'h2;
	localparam logic [1:0] STEP_THREE = 2'h3;

	// Modes 6 and 7 behave as 2 and 3
	function automatic itc_mode_t itc_eff_mode(input logic [2:0] m);
		if (m[2:1] == 2'b11)
			return itc_mode_t'({1'b0, m[1:0]});
		else
			return itc_mode_t'(m);
	endfunction : itc_eff_mode

	// One step down, binary or decimal digits, wrapping past zero
	function automatic logic [CW-1:0] itc_dec1(input logic [CW-1:0] v, input logic bcd);
		logic [CW-1:0] r;
		logic          borrow;
		r = v;
		borrow = 1'b1;
		if (!bcd)
			r = v - 16'h0001;
		else
			for (int i = 0; i < 4; i++)
				if (borrow)
				begin
					if (r[4*i +: 4] == 4'h0)
						r[4*i +: 4] = 4'h9;
					else
					begin
						r[4*i +: 4] = r[4*i +: 4] - 4'h1;
						borrow = 1'b0;
					end
				end
		return r;
	endfunction : itc_dec1

	function automatic logic [CW-1:0] itc_dec(input logic [CW-1:0] v, input logic [1:0] step,
		input logic bcd);
		logic [CW-1:0] r;
		r = v;
		for (int i = 0; i < 3; i++)
			if (2'(i) < step)
				r = itc_dec1(r, bcd);
		return r;
	endfunction : itc_dec

endpackage : itc_pkg

// File: src/itc_edge_if.sv
`timescale 1ns/1ps
interface itc_edge_if;
	logic clk_rise;
	logic clk_fall;
	logic gate_level;
	logic trig;

	modport src (
		output clk_rise,
		output clk_fall,
		output gate_level,
		output trig
	);

	modport dst (
		input clk_rise,
		input clk_fall,
		input gate_level,
		input trig
	);
endinterface : itc_edge_if

// File: src/itc_edge.sv
`timescale 1ns/1ps
module itc_edge
	import itc_pkg::*;
(
	// System
	input  wire logic clock,
	input  wire logic rst,
	// Counter pins
	input  wire logic ctr_clk,
	input  wire logic gate,
	// Events
	itc_edge_if.src   ev
);

	logic ctr_d_reg;
	logic gate_d_reg;
	logic rise_reg;
	logic fall_reg;
	logic trig_ff_reg;
	logic trig_smp_reg;
	logic level_reg;
	logic gate_edge;

	assign gate_edge     = gate & ~gate_d_reg;
	assign ev.clk_rise   = rise_reg;
	assign ev.clk_fall   = fall_reg;
	assign ev.gate_level = level_reg;
	assign ev.trig       = trig_smp_reg;

	// Counter clock edges
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ctr_d_reg <= 1'b0;
			rise_reg  <= 1'b0;
			fall_reg  <= 1'b0;
		end
		else
		begin
			ctr_d_reg <= ctr_clk;
			rise_reg  <= ctr_clk & ~ctr_d_reg;
			fall_reg  <= ~ctr_clk & ctr_d_reg;
		end
	end

	// Gate level and trigger capture
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			gate_d_reg   <= 1'b1;
			trig_ff_reg  <= 1'b0;
			trig_smp_reg <= 1'b0;
			level_reg    <= 1'b0;
		end
		else
		begin
			gate_d_reg <= gate;
			if (rise_reg)
			begin
				level_reg    <= gate_d_reg;
				trig_smp_reg <= trig_ff_reg | gate_edge;
				trig_ff_reg  <= 1'b0;
			end
			else
			begin
				trig_ff_reg <= trig_ff_reg | gate_edge;
				if (fall_reg)
					trig_smp_reg <= 1'b0;
			end
		end
	end

endmodule : itc_edge

// File: src/itc_top.sv
`timescale 1ns/1ps
module itc_top
	import itc_pkg::*;
(
	// System
	input  wire logic                clock,
	input  wire logic                rst,
	// Counter pins
	input  wire logic                ctr_clk,
	input  wire logic                gate,
	output logic                     timer_out,
	// Mode setting
	input  wire logic                mode_wr,
	input  wire logic [2:0]          mode_sel,
	input  wire logic                bcd_sel,
	input  wire logic [1:0]          rw_sel,
	// Count bytes
	input  wire logic                count_wr,
	input  wire logic [7:0]          count_byte,
	// Status
	output logic                     null_count
);

	import itc_pkg::*;

	itc_edge_if ev ();

	itc_mode_t       mode_reg;
	itc_rw_t         rw_reg;
	logic            bcd_reg;
	logic [CW-1:0]   count_holding_latch_reg;
	logic            msb_next_reg;
	logic            halt_reg;
	logic            have_count_reg;
	itc_run_t        run_reg;
	logic [CW-1:0]   count_reg;
	logic            out_reg;
	logic            armed_reg;
	logic            null_reg;

	itc_mode_t       new_mode;
	logic            count_done;
	logic            first_byte;
	logic            trig_mode;
	logic            load_now;
	logic            reload;
	logic            dec_en;
	logic [1:0]      step;
	logic [CW-1:0]   count_next;
	logic            m3_expire;
	logic            running;

	itc_edge u_edge (
		.clock   (clock),
		.rst     (rst),
		.ctr_clk (ctr_clk),
		.gate    (gate),
		.ev      (ev.src)
	);

	assign new_mode   = itc_eff_mode(mode_sel);
	assign timer_out  = out_reg;
	assign null_count = null_reg;
	assign running    = (run_reg == RUN_COUNT);

	// Count write decoding
	always_comb
	begin
		count_done = 1'b0;
		first_byte = 1'b0;
		if (count_wr && !mode_wr)
		begin
			if (rw_reg == RW_BOTH && !msb_next_reg)
				first_byte = 1'b1;
			else
				count_done = 1'b1;
		end
	end

	// Load, reload and decrement conditions
	always_comb
	begin
		trig_mode = 1'b0;
		dec_en    = 1'b0;
		step      = STEP_ONE;
		m3_expire = 1'b0;
		case (mode_reg)
			MODE_TERM:
				dec_en = ev.gate_level && !halt_reg;
			MODE_ONESH:
			begin
				trig_mode = 1'b1;
				dec_en    = 1'b1;
			end
			MODE_RATE:
			begin
				trig_mode = 1'b1;
				dec_en    = ev.gate_level;
			end
			MODE_SQUAR:
			begin
				trig_mode = 1'b1;
				dec_en    = ev.gate_level;
				if (count_reg[0] && out_reg)
					step = STEP_ONE;
				else if (count_reg[0])
					step = STEP_THREE;
				else
					step = STEP_TWO;
				m3_expire = (count_reg == 16'h0002) ||
					(!out_reg && count_reg == 16'h0003);
			end
			MODE_SWSTB:
				dec_en = ev.gate_level;
			MODE_HWSTB:
			begin
				trig_mode = 1'b1;
				dec_en    = 1'b1;
			end
			default:
				dec_en = 1'b0;
		endcase
	end

	assign load_now = ev.clk_fall && !halt_reg &&
		((run_reg == RUN_LOAD) || (ev.trig && trig_mode && have_count_reg));
	assign reload = ev.clk_fall && running && dec_en &&
		(((mode_reg == MODE_RATE) && (count_reg == 16'h0001)) ||
		((mode_reg == MODE_SQUAR) && m3_expire));
	assign count_next = itc_dec(count_reg, step, bcd_reg);

	// Mode setting
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			mode_reg <= MODE_RST;
			rw_reg   <= RW_RST;
			bcd_reg  <= 1'b0;
		end
		else if (mode_wr)
		begin
			mode_reg <= new_mode;
			rw_reg   <= (rw_sel == 2'b00) ? RW_RST : itc_rw_t'(rw_sel);
			bcd_reg  <= bcd_sel;
		end
	end

	// Count holding latch and byte order
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			count_holding_latch_reg <= COUNT_RST;
			msb_next_reg            <= 1'b0;
		end
		else if (mode_wr)
			msb_next_reg <= 1'b0;
		else if (count_wr)
		begin
			case (rw_reg)
				RW_LSB:
					count_holding_latch_reg <= {8'h00, count_byte};
				RW_MSB:
					count_holding_latch_reg <= {count_byte, 8'h00};
				RW_BOTH:
				begin
					if (!msb_next_reg)
						count_holding_latch_reg[7:0] <= count_byte;
					else
						count_holding_latch_reg[15:8] <= count_byte;
					msb_next_reg <= ~msb_next_reg;
				end
				default:
					count_holding_latch_reg <= {8'h00, count_byte};
			endcase
		end
	end

	// Halt between bytes and count availability
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			halt_reg       <= 1'b0;
			have_count_reg <= 1'b0;
		end
		else if (mode_wr)
		begin
			halt_reg       <= 1'b0;
			have_count_reg <= 1'b0;
		end
		else
		begin
			if (first_byte && mode_reg == MODE_TERM)
				halt_reg <= 1'b1;
			else if (count_done)
				halt_reg <= 1'b0;
			if (count_done)
				have_count_reg <= 1'b1;
		end
	end

	// Run state
	always_ff @(posedge clock)
	begin
		if (rst)
			run_reg <= RUN_IDLE;
		else if (mode_wr)
			run_reg <= RUN_IDLE;
		else if (count_done)
		begin
			case (mode_reg)
				MODE_TERM, MODE_SWSTB:
					run_reg <= RUN_LOAD;
				MODE_RATE, MODE_SQUAR:
					if (run_reg == RUN_IDLE)
						run_reg <= RUN_LOAD;
				default:
					run_reg <= run_reg;
			endcase
		end
		else if (load_now)
			run_reg <= RUN_COUNT;
	end

	// Counting element
	always_ff @(posedge clock)
	begin
		if (rst)
			count_reg <= COUNT_RST;
		else if (load_now || reload)
			count_reg <= count_holding_latch_reg;
		else if (ev.clk_fall && running && dec_en)
			count_reg <= count_next;
	end

	// Single strobe per load in strobe modes
	always_ff @(posedge clock)
	begin
		if (rst)
			armed_reg <= 1'b0;
		else if (mode_wr)
			armed_reg <= 1'b0;
		else if (load_now)
			armed_reg <= 1'b1;
		else if (ev.clk_fall && running && dec_en && count_next == COUNT_RST)
			armed_reg <= 1'b0;
	end

	// Null count flag, set wins over load
	always_ff @(posedge clock)
	begin
		if (rst)
			null_reg <= 1'b1;
		else if (mode_wr || count_done)
			null_reg <= 1'b1;
		else if (load_now || reload)
			null_reg <= 1'b0;
	end

	// Output waveform
	always_ff @(posedge clock)
	begin
		if (rst)
			out_reg <= OUT_RST;
		else if (mode_wr)
			out_reg <= (new_mode != MODE_TERM);
		else if (mode_reg == MODE_TERM && (count_done || first_byte))
			out_reg <= 1'b0;
		else if ((mode_reg == MODE_RATE || mode_reg == MODE_SQUAR) && !gate)
			out_reg <= 1'b1;
		else if (ev.clk_fall)
		begin
			case (mode_reg)
				MODE_TERM:
					if (running && dec_en && count_next == COUNT_RST)
						out_reg <= 1'b1;
				MODE_ONESH:
					if (load_now)
						out_reg <= 1'b0;
					else if (running && !out_reg && count_next == COUNT_RST)
						out_reg <= 1'b1;
				MODE_RATE:
					if (load_now || reload)
						out_reg <= 1'b1;
					else if (running && dec_en && count_reg == 16'h0002)
						out_reg <= 1'b0;
				MODE_SQUAR:
					if (load_now)
						out_reg <= 1'b1;
					else if (reload)
						out_reg <= ~out_reg;
				MODE_SWSTB, MODE_HWSTB:
					if (!out_reg)
						out_reg <= 1'b1;
					else if (running && dec_en && armed_reg && !load_now &&
						count_next == COUNT_RST)
						out_reg <= 1'b0;
				default:
					out_reg <= 1'b1;
			endcase
		end
	end

endmodule : itc_top

// File: testbench/itc_clk_src.sv
`timescale 1ns/1ps
module itc_clk_src
(
	// System
	input  wire logic clock,
	input  wire logic rst,
	// Counter clock pin and its fall count
	output logic      ctr_clk = 1'b0,
	output int        falls = 0
);
	logic [1:0] ph_reg = 2'h0;

	// Free running pin, four cycles a level, rise then fall
	always @(posedge clock)
	begin
		if (rst)
		begin
			ph_reg <= 2'h0;
			ctr_clk <= 1'b0;
			falls <= 0;
		end
		else
		begin
			ph_reg <= ph_reg + 2'h1;
			if (ph_reg == 2'h3)
			begin
				ctr_clk <= !ctr_clk;
				if (ctr_clk)
					falls <= falls + 1;
			end
		end
	end
endmodule : itc_clk_src

// File: testbench/itc_assertions.sv
`timescale 1ns/1ps
module itc_assertions
(
	// Watched ports
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       ctr_clk,
	input wire logic       gate,
	input wire logic       timer_out,
	input wire logic       mode_wr,
	input wire logic [2:0] mode_sel,
	input wire logic       count_wr,
	input wire logic       null_count
);
	logic [2:0] mode_reg;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// Effective mode, 6 and 7 fold onto 2 and 3
	always_ff @(posedge clock)
	begin
		if (rst)
			mode_reg <= 3'h0;
		else if (mode_wr)
			mode_reg <= (mode_sel[2:1] == 2'b11) ? {1'b0, mode_sel[1:0]} : mode_sel;
	end

	mode_out_a: assert property (mode_wr |=> timer_out == ($past(mode_sel) != 3'h0))
		else $error("timer_out wrong after mode write");
	mode_null_a: assert property (mode_wr |=> null_count)
		else $error("null_count not set by mode write");
	zero_rise_a: assert property ($rose(timer_out) && mode_reg == 3'h0
		|-> $past(ctr_clk, 3) && !$past(ctr_clk, 2))
		else $error("mode 0 output rose off a counter fall");
	null_load_a: assert property ($fell(null_count)
		|-> $past(ctr_clk, 3) && !$past(ctr_clk, 2))
		else $error("count loaded off a counter fall");
	zero_write_a: assert property (mode_reg == 3'h0 && count_wr && !mode_wr |=> !timer_out)
		else $error("mode 0 count write left output high");
	gate_high_a: assert property ((mode_reg == 3'h2 || mode_reg == 3'h3) && !gate
		&& !mode_wr |=> timer_out)
		else $error("gate low did not force output high");
	rate_pulse_a: assert property ($fell(timer_out) && mode_reg == 3'h2
		|-> ##[1:12] (timer_out || mode_wr))
		else $error("mode 2 low pulse too long");
	strobe_len_a: assert property ($fell(timer_out) && mode_reg == 3'h4
		|-> !timer_out ##[1:12] (timer_out || mode_wr))
		else $error("mode 4 strobe too long");

	cover property ($rose(timer_out) && mode_reg == 3'h1);
	cover property ($fell(timer_out) && mode_reg == 3'h3);
	cover property ($fell(null_count));
endmodule : itc_assertions

bind itc_top itc_assertions u_chk (.clock(clock), .rst(rst), .ctr_clk(ctr_clk), .gate(gate),
	.timer_out(timer_out), .mode_wr(mode_wr), .mode_sel(mode_sel), .count_wr(count_wr),
	.null_count(null_count));

// File: testbench/itc_top_tb.sv
`timescale 1ns/1ps
module itc_top_tb;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       ctr_clk;
	logic       gate = 1'b1;
	logic       timer_out;
	logic       mode_wr = 1'b0;
	logic [2:0] mode_sel = 3'h0;
	logic [1:0] rw_sel = 2'b01;
	logic       bcd_sel = 1'b0;
	logic       count_wr = 1'b0;
	logic [7:0] count_byte = 8'h00;
	logic       null_count;
	int         falls;
	int         cyc = 0;
	int         err_count = 0;
	int         num_checks = 0;

	always #50 clock = !clock;

	itc_clk_src src (.clock(clock), .rst(rst), .ctr_clk(ctr_clk), .falls(falls));

	itc_top dut (.clock(clock), .rst(rst), .ctr_clk(ctr_clk), .gate(gate),
		.timer_out(timer_out), .mode_wr(mode_wr), .mode_sel(mode_sel), .bcd_sel(bcd_sel),
		.rw_sel(rw_sel), .count_wr(count_wr), .count_byte(count_byte),
		.null_count(null_count));

	task wrap_up;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_count++;
			wrap_up;
		end
	end

	task step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step

	task chk_out(input logic e);
		num_checks++;
		if (timer_out !== e)
		begin
			err_count++;
			$display("Error timer_out exp %b got %b", e, timer_out);
		end
	endtask : chk_out

	task chk_n(input int e, input int g);
		num_checks++;
		if (e != g)
		begin
			err_count++;
			$display("Error fall count exp %0d got %0d", e, g);
		end
	endtask : chk_n

	// Waits for a counter pin fall, then n more cycles
	task sync(input int n);
		int f;
		f = falls;
		while (falls == f)
			step(1);
		step(n);
	endtask : sync

	task wm(input logic [2:0] m);
		mode_sel = m;
		mode_wr = 1'b1;
		step(1);
		mode_wr = 1'b0;
	endtask : wm

	task wc(input logic [7:0] b);
		count_byte = b;
		count_wr = 1'b1;
		step(1);
		count_wr = 1'b0;
	endtask : wc

	task trig;
		gate = 1'b0;
		step(1);
		gate = 1'b1;
	endtask : trig

	// Counts pin falls until the output reaches lvl
	task fto(input logic lvl, input int e);
		int f;
		int k;
		f = falls;
		k = 0;
		while (timer_out !== lvl && k < 200)
		begin
			step(1);
			k++;
		end
		chk_n(e, falls - f);
	endtask : fto

	task t_mode0;
		wm(3'h0);
		chk_out(1'b0);
		sync(3);
		wc(8'h03);
		fto(1'b1, 4);
		step(40);
		chk_out(1'b1);
		gate = 1'b0;
		sync(3);
		wc(8'h02);
		step(40);
		chk_out(1'b0);
		sync(0);
		gate = 1'b1;
		fto(1'b1, 2);
	endtask : t_mode0

	task t_mode1;
		wm(3'h1);
		chk_out(1'b1);
		sync(3);
		wc(8'h03);
		step(40);
		chk_out(1'b1);
		sync(0);
		trig;
		fto(1'b0, 1);
		wc(8'h05);
		fto(1'b1, 3);
		sync(0);
		trig;
		step(20);
		sync(0);
		trig;
		fto(1'b1, 6);
	endtask : t_mode1

	task t_mode2;
		wm(3'h2);
		chk_out(1'b1);
		sync(3);
		wc(8'h03);
		fto(1'b0, 3);
		fto(1'b1, 1);
		fto(1'b0, 2);
		gate = 1'b0;
		step(2);
		chk_out(1'b1);
		sync(0);
		gate = 1'b1;
		fto(1'b0, 3);
	endtask : t_mode2

	task t_mode3;
		wm(3'h3);
		sync(3);
		wc(8'h05);
		fto(1'b0, 4);
		fto(1'b1, 2);
		fto(1'b0, 3);
		wc(8'h04);
		fto(1'b1, 2);
		fto(1'b0, 2);
		fto(1'b1, 2);
	endtask : t_mode3

	task t_strobe;
		wm(3'h4);
		chk_out(1'b1);
		sync(3);
		wc(8'h02);
		fto(1'b0, 3);
		fto(1'b1, 1);
		wm(3'h5);
		sync(3);
		wc(8'h02);
		step(40);
		chk_out(1'b1);
		sync(0);
		trig;
		fto(1'b0, 3);
		fto(1'b1, 1);
	endtask : t_strobe

	// Two-byte counts in modes 0 and 4
	task t_two;
		rw_sel = 2'b11;
		wm(3'h0);
		wc(8'h02);
		sync(3);
		wc(8'h00);
		fto(1'b1, 3);
		wc(8'h03);
		chk_out(1'b0);
		sync(3);
		wc(8'h00);
		sync(3);
		wc(8'h01);
		step(40);
		chk_out(1'b0);
		sync(3);
		wc(8'h00);
		fto(1'b1, 2);
		wm(3'h4);
		wc(8'h02);
		sync(3);
		wc(8'h00);
		sync(3);
		wc(8'h05);
		fto(1'b0, 2);
		fto(1'b1, 1);
		sync(3);
		wc(8'h00);
		fto(1'b0, 6);
		fto(1'b1, 1);
		rw_sel = 2'b01;
	endtask : t_two

	// Decimal-coded square wave, count ten
	task t_bcd;
		bcd_sel = 1'b1;
		wm(3'h3);
		sync(3);
		wc(8'h10);
		fto(1'b0, 6);
		fto(1'b1, 5);
		bcd_sel = 1'b0;
	endtask : t_bcd

	initial
	begin
		step(16);
		rst = 1'b0;
		step(3);
		t_mode0;
		t_mode1;
		t_mode2;
		t_mode3;
		t_strobe;
		t_two;
		t_bcd;
		wrap_up;
	end
endmodule : itc_top_tb
